// ---- logic/increment_or_jump_exec.sv ----
// execution logic for increment, increment-skip, jump and or instructions
//
// Function
// - increment-skip adds one, flags untouched
// - zero result skips next, two cycles
// - destination bit zero work, one file
// - file operand is seven-bit address
// - jump loads eleven-bit target into pc
// - jump copies latch bits 4:3 upward
// - jump unconditional, takes two cycles
// - or literal into work, update zero
// - increment register, store, update zero
// - or work with register, update zero
`timescale 1ns/1ps
module increment_or_jump_exec (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic issue_in,
  input wire logic [5:0] op_in,
  input wire logic [exec_pkg::FADDR_W-1:0] faddr_in,
  input wire logic dest_in,
  input wire logic [exec_pkg::DATA_W-1:0] literal_in,
  input wire logic [exec_pkg::JUMP_W-1:0] target_in,
  input wire logic [exec_pkg::DATA_W-1:0] pc_high_latch_in,
  output logic ready_out,
  output logic done_out,
  output logic squash_next_out,
  output logic [exec_pkg::DATA_W-1:0] work_out,
  output logic zero_out,
  output logic [exec_pkg::PC_W-1:0] pc_out,
  output logic pc_load_out
);
  ////////////////////////////////////////////////////////////////////////
  file_port_if fport ();

  file_regs #(.DEPTH(exec_pkg::FILE_DEPTH)) u_regs (
    .core_clk_in(core_clk_in),
    .port(fport)
  );

  ////////////////////////////////////////////////////////////////////////
  // two-step flow: cycle 1 reads the operand, cycle 2 executes.
  // ops without a file operand still take the read step, trading speed
  // for a single uniform timing that is easy to sequence.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_EXEC = 3'b010,
    PH_BUBBLE = 3'b100
  } phase_t;

  phase_t ph_q, ph_d;
  logic [5:0] op_q;
  logic [exec_pkg::FADDR_W-1:0] faddr_q;
  logic dest_q;
  logic [exec_pkg::DATA_W-1:0] lit_q;
  logic [exec_pkg::JUMP_W-1:0] target_q;
  logic [1:0] latch_hi_q;
  logic [exec_pkg::DATA_W-1:0] work_q, work_d;
  logic zero_q, zero_d;
  logic [exec_pkg::PC_W-1:0] pc_q, pc_d;
  logic pc_load_q;
  logic done_q;
  logic squash_q;

  wire take = issue_in && (ph_q == PH_IDLE);
  wire in_exec = (ph_q == PH_EXEC);
  wire is_inc_skip = in_exec && (op_q == exec_pkg::OP_INC_SKIP);
  wire is_jump = in_exec && (op_q == exec_pkg::OP_JUMP);
  wire is_or_lit = in_exec && (op_q == exec_pkg::OP_OR_LIT);
  wire is_inc = in_exec && (op_q == exec_pkg::OP_INC);
  wire is_or_reg = in_exec && (op_q == exec_pkg::OP_OR_REG);

  ////////////////////////////////////////////////////////////////////////
  // datapath; increment wraps naturally in eight bits
  wire [exec_pkg::DATA_W-1:0] inc_res = fport.rdata + 8'h01;
  wire [exec_pkg::DATA_W-1:0] or_reg_res = work_q | fport.rdata;
  wire [exec_pkg::DATA_W-1:0] or_lit_res = work_q | lit_q;
  wire uses_inc = is_inc || is_inc_skip;
  wire [exec_pkg::DATA_W-1:0] reg_res = uses_inc ? inc_res : or_reg_res;
  wire has_dest = uses_inc || is_or_reg;
  wire to_file = has_dest && (dest_q == exec_pkg::DEST_FILE);
  wire to_work = (has_dest && (dest_q == exec_pkg::DEST_WORK)) || is_or_lit;
  wire [exec_pkg::DATA_W-1:0] result = is_or_lit ? or_lit_res : reg_res;
  wire sets_zero = is_inc || is_or_reg || is_or_lit;
  wire skip_hit = is_inc_skip && (inc_res == 8'h00);

  // seven-bit operand address straight from the instruction word; the read
  // data are registered, so the address is presented on the issue edge
  assign fport.addr = take ? faddr_in : faddr_q;
  assign fport.we = to_file;
  assign fport.wdata = reg_res;

  assign work_d = to_work ? result : work_q;
  assign zero_d = sets_zero ? (result == 8'h00) : zero_q;
  assign pc_d = is_jump ? {latch_hi_q, target_q} : pc_q;

  ////////////////////////////////////////////////////////////////////////
  // sequencing: jump and a taken skip both spend a bubble cycle
  always_comb begin
    ph_d = ph_q;
    case (ph_q)
      PH_IDLE: begin
        if (issue_in) begin
          ph_d = PH_EXEC;
        end
      end
      PH_EXEC: begin
        if (is_jump || skip_hit) begin
          ph_d = PH_BUBBLE;
        end else begin
          ph_d = PH_IDLE;
        end
      end
      PH_BUBBLE: begin
        ph_d = PH_IDLE;
      end
      default: begin
        ph_d = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q <= PH_IDLE;
    end else begin
      ph_q <= ph_d;
    end
  end

  // operand capture at issue
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_q <= exec_pkg::OP_NONE;
      faddr_q <= '0;
      dest_q <= exec_pkg::DEST_WORK;
      lit_q <= exec_pkg::DATA_RESET;
      target_q <= '0;
      latch_hi_q <= '0;
    end else if (take) begin
      op_q <= op_in;
      faddr_q <= faddr_in;
      dest_q <= dest_in;
      lit_q <= literal_in;
      target_q <= target_in;
      latch_hi_q <= pc_high_latch_in[exec_pkg::LATCH_UPPER_LO+1:exec_pkg::LATCH_UPPER_LO];
    end
  end

  // architectural state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      work_q <= exec_pkg::DATA_RESET;
      zero_q <= 1'b0;
      pc_q <= exec_pkg::PC_RESET;
    end else begin
      work_q <= work_d;
      zero_q <= zero_d;
      pc_q <= pc_d;
    end
  end

  // completion strobes, registered
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_load_q <= 1'b0;
      done_q <= 1'b0;
      squash_q <= 1'b0;
    end else begin
      pc_load_q <= is_jump;
      squash_q <= skip_hit;
      done_q <= (in_exec && !(is_jump || skip_hit)) || (ph_q == PH_BUBBLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unknown op codes finish as a no-op with nothing written
  assign ready_out = (ph_q == PH_IDLE);
  assign done_out = done_q;
  assign squash_next_out = squash_q;
  assign work_out = work_q;
  assign zero_out = zero_q;
  assign pc_out = pc_q;
  assign pc_load_out = pc_load_q;
endmodule : increment_or_jump_exec

// ---- logic/exec_pkg.sv ----
// constants and types for the increment / jump / or execution block
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int JUMP_W = 11;
  localparam int PC_W = 13;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam int LATCH_UPPER_LO = 3;
  localparam int CYCLES_JUMP = 2;
  localparam int CYCLES_SKIP = 2;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [5:0] {
    OP_NONE = 6'b000001,
    OP_INC_SKIP = 6'b000010,
    OP_JUMP = 6'b000100,
    OP_OR_LIT = 6'b001000,
    OP_INC = 6'b010000,
    OP_OR_REG = 6'b100000
  } op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_BUBBLE = 2'b10
  } state_t;
endpackage : exec_pkg

// ---- logic/file_port_if.sv ----
// interface carrying the file-register read/write port
`timescale 1ns/1ps
interface file_port_if;
  logic [exec_pkg::FADDR_W-1:0] addr;
  logic [exec_pkg::DATA_W-1:0] rdata;
  logic we;
  logic [exec_pkg::DATA_W-1:0] wdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : file_port_if

// ---- logic/file_regs.sv ----
// file register memory, registered read data
`timescale 1ns/1ps
module file_regs #(
  parameter int DEPTH = exec_pkg::FILE_DEPTH
) (
  input wire logic core_clk_in,
  file_port_if.mem port
);
  logic [exec_pkg::DATA_W-1:0] mem_q [DEPTH];
  logic [exec_pkg::DATA_W-1:0] rdata_q;

  // write-first so a back-to-back read sees the new value
  always_ff @(posedge core_clk_in) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    rdata_q <= port.we ? port.wdata : mem_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule : file_regs

// ---- tb/exec_assertions.sv ----
// port-level assertions for the execution block
`timescale 1ns/1ps
module exec_assertions (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic issue_in,
  input wire logic [5:0] op_in,
  input wire logic [7:0] literal_in,
  input wire logic [10:0] target_in,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic ready_out,
  input wire logic done_out,
  input wire logic squash_next_out,
  input wire logic [7:0] work_out,
  input wire logic zero_out,
  input wire logic [12:0] pc_out,
  input wire logic pc_load_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire logic take_w = issue_in && ready_out;
  wire logic [1:0] upper_w = pc_high_latch_in[4:3];
  sequence s_take(logic [5:0] op);
    take_w && op_in == op;
  endsequence
  // long ops end with a strobe, then done one cycle later
  sequence s_long_end;
    pc_load_out ##1 done_out;
  endsequence
  chk_take_busy: assert property (take_w |=> !ready_out)
    else $error("ready high after take");
  chk_jump_pc: assert property (s_take(exec_pkg::OP_JUMP) |-> ##2
    pc_out == {$past(upper_w, 2), $past(target_in, 2)}) else $error("jump pc wrong");
  chk_jump_long: assert property (s_take(exec_pkg::OP_JUMP) |-> ##2 s_long_end)
    else $error("jump not two cycles");
  chk_skip_end: assert property (squash_next_out |-> !ready_out ##1 done_out)
    else $error("skip bubble missing");
  chk_flags_kept: assert property (take_w && (op_in == exec_pkg::OP_JUMP ||
    op_in == exec_pkg::OP_INC_SKIP) |-> ##3 zero_out == $past(zero_out, 3))
    else $error("zero changed");
  chk_or_lit: assert property (s_take(exec_pkg::OP_OR_LIT) |-> ##2
    work_out == ($past(work_out, 2) | $past(literal_in, 2)) && zero_out == (work_out == 8'h00))
    else $error("or literal wrong");
  chk_normal_done: assert property (take_w && (op_in == exec_pkg::OP_INC ||
    op_in == exec_pkg::OP_OR_REG) |-> ##2 done_out && !squash_next_out && !pc_load_out)
    else $error("short op timing wrong");
  chk_pc_still: assert property (take_w && op_in != exec_pkg::OP_JUMP |-> ##2 $stable(pc_out))
    else $error("pc moved");
endmodule : exec_assertions

// ---- tb/tb.sv ----
// self-checking bench for the execution block
`timescale 1ns/1ps
module tb;
  logic core_clk_in = 0, rst_in = 1, issue_in = 0, dest_in = 0;
  logic [5:0] op_in = 6'h01;
  logic [6:0] faddr_in = 7'h00;
  logic [7:0] literal_in = 8'h00, pc_high_latch_in = 8'h00, work_out;
  logic [10:0] target_in = 11'h000;
  logic ready_out, done_out, squash_next_out, zero_out, pc_load_out, long_seen;
  logic [12:0] pc_out;
  int n_mismatch = 0, compares = 0, lat;
  increment_or_jump_exec increment_or_jump_exec_inst (.*);
  initial forever #5 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // offers one instruction, then counts cycles up to done
  task automatic run(logic [5:0] op, logic [6:0] fa, logic d, logic [7:0] lit);
    @(posedge core_clk_in) #1;
    op_in = op;
    faddr_in = fa;
    dest_in = d;
    literal_in = lit;
    issue_in = 1;
    @(posedge core_clk_in) #1;
    issue_in = 0;
    lat = 1;
    long_seen = 0;
    while (done_out !== 1'b1) begin
      long_seen |= (squash_next_out === 1'b1) || (pc_load_out === 1'b1);
      if (lat > 5) begin
        n_mismatch++;
        conclude();
      end
      @(posedge core_clk_in) #1;
      lat++;
    end
  endtask : run
  ////////////////////////////////////////////////////////////////
  task automatic t_or_literal();
    run(exec_pkg::OP_OR_LIT, 7'h00, 1'b0, 8'h00);
    check("or zero", {zero_out, work_out}, 13'h0100);
    run(exec_pkg::OP_OR_LIT, 7'h00, 1'b0, 8'ha5);
    check("or a5", {zero_out, work_out}, 13'h00a5);
    check("or lat", 13'(lat), 13'h0002);
  endtask : t_or_literal
  // work all ones makes the unwritten file contents irrelevant
  task automatic t_or_register();
    run(exec_pkg::OP_OR_LIT, 7'h00, 1'b0, 8'hff);
    run(exec_pkg::OP_OR_REG, 7'h7f, 1'b1, 8'h00);
    check("orreg", {zero_out, work_out}, 13'h00ff);
    run(exec_pkg::OP_OR_REG, 7'h00, 1'b1, 8'h00);
  endtask : t_or_register
  task automatic t_skip();
    run(exec_pkg::OP_INC_SKIP, 7'h7f, 1'b1, 8'h00);
    check("skip w", {zero_out, work_out}, 13'h00ff);
    check("skip l", {long_seen, 12'(lat)}, 13'h1003);
    run(exec_pkg::OP_INC_SKIP, 7'h7f, 1'b0, 8'h00);
    check("noskip w", {zero_out, work_out}, 13'h0001);
    check("noskip l", {long_seen, 12'(lat)}, 13'h0002);
  endtask : t_skip
  task automatic t_increment();
    run(exec_pkg::OP_INC, 7'h00, 1'b0, 8'h00);
    check("inc wrap", {zero_out, work_out}, 13'h0100);
    run(exec_pkg::OP_INC, 7'h7f, 1'b1, 8'h00);
    run(exec_pkg::OP_INC, 7'h7f, 1'b0, 8'h00);
    check("inc file", {zero_out, work_out}, 13'h0002);
  endtask : t_increment
  task automatic t_jump();
    pc_high_latch_in = 8'h18;
    target_in = 11'h7ff;
    run(exec_pkg::OP_JUMP, 7'h00, 1'b0, 8'h00);
    check("jump pc", pc_out, 13'h1fff);
    check("jump l", {long_seen, 12'(lat)}, 13'h1003);
    pc_high_latch_in = 8'he7;
    target_in = 11'h555;
    run(exec_pkg::OP_JUMP, 7'h00, 1'b0, 8'h00);
    check("jump pc2", pc_out, 13'h0555);
    check("jump z", {zero_out, work_out}, 13'h0002);
  endtask : t_jump
  initial begin
    repeat (20) @(posedge core_clk_in);
    #1 rst_in = 0;
    t_or_literal();
    t_or_register();
    t_skip();
    t_increment();
    t_jump();
    conclude();
  end
endmodule : tb
bind increment_or_jump_exec exec_assertions exec_assertions_inst (.*);
